// file: hdl/smab_bus.v
// memory-side shared address and data bus port of a stacked flash/ram package
// assumes all pins are asynchronous to clk_sys; core array sits behind core_* ports
`timescale 1ns/1ps
`default_nettype none
`include "smab_consts.vh"

// Behaviour
// - word address width set by density: top bit 22, 21, 20 or 19.
// - one address input set shared by all dies for reads and writes.
// - address counts 16-bit words; lowest bit steps one word.
// - non-mux: host drives write data, device drives read data.
// - data lines released whenever deselected or outputs disabled.
// - mux read: host gives lower address on data lines, then device drives data.
// - address/data sharing only in the mux variant; non-mux keeps address pins.
// - address latched on first and every second later clock edge with strobe low, or on strobe rising if not already held.
module smab_bus (
  // clock and reset
  input wire clk_sys,
  input wire resetn,
  // configuration
  input wire [1:0] density,
  input wire mux_mode,
  // bus pins
  input wire bus_clk,
  input wire address_valid_strobe_n,
  input wire chip_sel_n,
  input wire out_en_n,
  input wire write_en_n,
  input wire [`SMAB_ADDR_W-1:0] addr_in,
  input wire [`SMAB_DATA_W-1:0] dq_in,
  output reg [`SMAB_DATA_W-1:0] dq_out,
  output wire dq_oe,
  // core side
  output reg [`SMAB_ADDR_W-1:0] core_addr,
  output reg core_addr_valid,
  output reg core_wr,
  output reg [`SMAB_DATA_W-1:0] core_wdata,
  output wire core_rd,
  input wire [`SMAB_DATA_W-1:0] core_rdata
);

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  function [`SMAB_ADDR_W-1:0] smab_mask;
    input [1:0] d;
    begin
      case (d)
        `SMAB_DENS_16M: smab_mask = 23'h0fffff;
        `SMAB_DENS_32M: smab_mask = 23'h1fffff;
        `SMAB_DENS_64M: smab_mask = 23'h3fffff;
        default: smab_mask = 23'h7fffff;
      endcase
    end
  endfunction

  // ------------------------------------------------------------
  // pin synchronisers
  // ------------------------------------------------------------
  localparam SYW = 5 + `SMAB_ADDR_W + `SMAB_DATA_W;
  reg [SYW-1:0] sy1_r;
  reg [SYW-1:0] sy2_r;
  always @(posedge clk_sys) begin
    if (!resetn) begin
      sy1_r <= {SYW{1'b0}};
      sy2_r <= {SYW{1'b0}};
    end else begin
      sy1_r <= {bus_clk, address_valid_strobe_n, chip_sel_n, out_en_n, write_en_n,
                addr_in, dq_in};
      sy2_r <= sy1_r;
    end
  end
  wire s_clk = sy2_r[SYW-1];
  wire s_adv_n = sy2_r[SYW-2];
  wire s_cs_n = sy2_r[SYW-3];
  wire s_oe_n = sy2_r[SYW-4];
  wire s_we_n = sy2_r[SYW-5];
  wire [`SMAB_ADDR_W-1:0] s_addr = sy2_r[`SMAB_DATA_W +: `SMAB_ADDR_W];
  wire [`SMAB_DATA_W-1:0] s_dq = sy2_r[`SMAB_DATA_W-1:0];

  // ------------------------------------------------------------
  // address latch
  // ------------------------------------------------------------
  reg clk_d_r;
  reg adv_d_r;
  reg held_r;
  wire clk_rise = s_clk & ~clk_d_r;
  wire adv_rise = s_adv_n & ~adv_d_r;
  wire strobe_low = ~s_adv_n & ~s_cs_n;
  // first clock edge with strobe low, then every second such edge; strobe release latches if held_r is clear
  wire latch = ~held_r & ~s_cs_n & ((strobe_low & clk_rise) | adv_rise);
  // mux variant takes low word from data lines, non-mux from address pins
  wire [`SMAB_ADDR_W-1:0] raw_addr = mux_mode ? {s_addr[`SMAB_ADDR_W-1:`SMAB_MUX_LOW_W], s_dq}
                                              : s_addr;
  always @(posedge clk_sys) begin
    if (!resetn) begin
      clk_d_r <= 1'b0;
      adv_d_r <= 1'b1;
      held_r <= 1'b0;
      core_addr <= {`SMAB_ADDR_W{1'b0}};
      core_addr_valid <= 1'b0;
    end else begin
      clk_d_r <= s_clk;
      adv_d_r <= s_adv_n;
      if (s_cs_n) begin
        held_r <= 1'b0;
        core_addr_valid <= 1'b0;
      end else if (latch) begin
        held_r <= 1'b1;
        core_addr_valid <= 1'b1;
        // word address, bits above density ignored; one set for all dies
        core_addr <= raw_addr & smab_mask(density);
      end else if (strobe_low & ~held_r) begin
        held_r <= 1'b0;
      end
      if (held_r & strobe_low & clk_rise) begin
        held_r <= 1'b0;
      end
    end
  end

  // ------------------------------------------------------------
  // data phase
  // ------------------------------------------------------------
  wire data_phase = core_addr_valid & s_adv_n;
  wire rd_phase = data_phase & s_we_n & ~s_oe_n;
  assign core_rd = rd_phase;
  // drive only when selected, outputs enabled, reading, address phase over
  assign dq_oe = rd_phase & ~chip_sel_n & ~out_en_n;
  always @(posedge clk_sys) begin
    if (!resetn) begin
      dq_out <= {`SMAB_DATA_W{1'b0}};
      core_wr <= 1'b0;
      core_wdata <= {`SMAB_DATA_W{1'b0}};
    end else begin
      dq_out <= core_rdata;
      // write data sampled on bus clock edge in data phase
      core_wr <= data_phase & ~s_we_n & clk_rise;
      if (data_phase & ~s_we_n & clk_rise) begin
        core_wdata <= s_dq;
      end
    end
  end

endmodule // smab_bus
`default_nettype wire

// file: pkg/smab_consts.vh
// constants for the stacked memory shared address/data bus port
// assumes inclusion by hdl/smab_bus.v only
`ifndef SMAB_CONSTS_VH
`define SMAB_CONSTS_VH
// density codes
`define SMAB_DENS_16M 2'h0
`define SMAB_DENS_32M 2'h1
`define SMAB_DENS_64M 2'h2
`define SMAB_DENS_128M 2'h3
// top address bit per density
`define SMAB_TOP_16M 5'h13
`define SMAB_TOP_32M 5'h14
`define SMAB_TOP_64M 5'h15
`define SMAB_TOP_128M 5'h16
// widths
`define SMAB_ADDR_W 23
`define SMAB_DATA_W 16
`define SMAB_MUX_LOW_W 16
`endif

// file: sim/smab_bus_monitor.sv
// port checker bound into smab_bus; sees its ports only
`timescale 1ns/1ps
`default_nettype none
module smab_bus_monitor (input wire clk_sys, resetn, mux_mode, address_valid_strobe_n,
  chip_sel_n, out_en_n, dq_oe, core_addr_valid, core_wr, core_rd, input wire [1:0] density,
  input wire [22:0] addr_in, core_addr, input wire [15:0] dq_in, dq_out, core_rdata);
  wire [22:0] m = (23'h1 << (5'h14 + density)) - 23'h1;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!resetn);
  property p_z; chip_sel_n | out_en_n |-> !dq_oe; endproperty
  a_z: assert property (p_z) else $error("dq driven");
  property p_m; core_addr_valid |-> (core_addr & ~m) == 23'h0; endproperty
  a_m: assert property (p_m) else $error("mask");
  property p_a; $rose(core_addr_valid) |->
    core_addr == ((mux_mode ? {addr_in[22:16], dq_in} : addr_in) & m); endproperty
  a_a: assert property (p_a) else $error("addr");
  property p_r; dq_oe |-> core_rd; endproperty
  a_r: assert property (p_r) else $error("phase");
  property p_d; dq_oe && $past(dq_oe) |-> dq_out == $past(core_rdata); endproperty
  a_d: assert property (p_d) else $error("rdata");
  property p_w; core_wr |-> core_addr_valid; endproperty
  a_w: assert property (p_w) else $error("write");
  property p_l; $rose(address_valid_strobe_n) && !chip_sel_n |-> ##[0:6] core_addr_valid;
  endproperty
  a_l: assert property (p_l) else $error("latch");
  property p_e; $rose(chip_sel_n) |-> ##[1:5] !core_addr_valid; endproperty
  a_e: assert property (p_e) else $error("clear");
  c_m: cover property (mux_mode && $rose(core_addr_valid));
  c_r: cover property ($rose(dq_oe));
  c_w: cover property (core_wr);
endmodule // smab_bus_monitor
bind smab_bus smab_bus_monitor u_mon (.*);
`default_nettype wire

// file: sim/smab_host.sv
// host controller model on the bus pins; bench resolves dq
`timescale 1ns/1ps
`default_nettype none
module smab_host (input wire clk_sys, output var logic bus_clk = 0, h_oe = 0,
  address_valid_strobe_n = 1, chip_sel_n = 1, out_en_n = 1, write_en_n = 1,
  output var logic [22:0] addr_in = 0, output var logic [15:0] h_d = 0);
  task tk(int n); repeat (n) @(posedge clk_sys); #1; endtask
  task adr(logic m, w, logic [22:0] a, logic [15:0] d);
    tk(1); chip_sel_n = 0; address_valid_strobe_n = 0; addr_in = a;
    h_d = m ? a[15:0] : d; h_oe = m;
    tk(2); bus_clk = 1; tk(6); bus_clk = 0;
    address_valid_strobe_n = 1; h_oe = w; h_d = d;
  endtask
  task dat(logic w);
    write_en_n = !w; out_en_n = w; tk(1); bus_clk = 1; tk(6); bus_clk = 0;
  endtask
  task fin; tk(1); chip_sel_n = 1; out_en_n = 1; write_en_n = 1; h_oe = 0; tk(4); endtask
endmodule // smab_host
`default_nettype wire

// file: sim/stacked_memory_addr_data_bus_tb.sv
// bench for smab_bus; host model and bound checker beside it
`timescale 1ns/1ps
`default_nettype none
module stacked_memory_addr_data_bus_tb;
  logic clk_sys = 0, resetn = 0, mux_mode = 0;
  logic [1:0] density = 0;
  logic [15:0] wd = 0;
  int error_cnt = 0, tests_run = 0, cyc = 0;
  wire bus_clk, address_valid_strobe_n, chip_sel_n, out_en_n, write_en_n, h_oe, dq_oe;
  wire core_addr_valid, core_wr, core_rd;
  wire [22:0] addr_in, core_addr;
  wire [15:0] h_d, dq_out, core_wdata, core_rdata = ~core_addr[15:0];
  wire [15:0] dq_in = dq_oe ? dq_out : h_oe ? h_d : ~h_d; // released lines drift
  smab_host u_host (.*);
  smab_bus u_dut (.*);
  always #20 clk_sys = ~clk_sys;
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (core_wr) wd <= core_wdata;
    if (cyc == 1000) begin error_cnt++; tally_and_finish; end
  end
  task chk(string n, logic [22:0] s, e);
    tests_run++;
    if (s !== e) begin error_cnt++; $display("[FAIL] %s exp %h got %h", n, e, s); end
  endtask
  task acc(logic m, w, logic [1:0] dn, logic [22:0] a, logic [15:0] d);
    logic [22:0] e;
    e = a & ((23'h1 << (5'h14 + dn)) - 23'h1);
    mux_mode = m; density = dn;
    u_host.adr(m, w, a, d); chk("addr", core_addr, e);
    u_host.dat(w);
    if (w) chk("wdat", 23'(wd), 23'(d));
    else begin
      chk("rdat", 23'({dq_oe, dq_out}), 23'({1'h1, ~e[15:0]}));
      chk("rd", 23'(core_rd), 23'h1);
    end
    u_host.fin(); chk("oe", 23'(dq_oe), 23'h0);
  endtask
  task tally_and_finish;
    if (error_cnt == 0 && tests_run > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    repeat (12) @(posedge clk_sys); #1 resetn = 1; repeat (3) @(posedge clk_sys); #1;
    for (int i = 0; i < 8; i++) acc(i[0], 1'h0, i[2:1], 23'h7ff35a, 16'h0);
    acc(1'h0, 1'h1, 2'h3, 23'h2a5a5a, 16'hc3a1); acc(1'h1, 1'h1, 2'h0, 23'h15a5a5, 16'h1e2d);
    tally_and_finish;
  end
endmodule // stacked_memory_addr_data_bus_tb
`default_nettype wire
